// ==== ilc_pkg.sv ====
// Shared constants and types of the interrupt and low-power controller
package ilc_pkg;
   // ***********************************************************
   // Register map (byte addresses) and field layout
   // ***********************************************************
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_FLAG = 8'h04;
   localparam logic [7:0] A_EN = 8'h08;
   localparam logic [7:0] A_STAT = 8'h0C;
   localparam int C_DLY = 0;
   localparam int C_WATCHDOG_DISABLE_BIT = 1;
   localparam int C_EDGE = 2;
   localparam logic [2:0] CTRL_RST = 3'h1;
   localparam logic [7:0] FLAG_RST = 8'h00;
   localparam logic [7:0] EN_RST = 8'h00;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // ***********************************************************
   // Condition code bit positions
   // ***********************************************************
   localparam int CCR_S = 7;
   localparam int CCR_X = 6;
   localparam int CCR_I = 4;
   // ***********************************************************
   // Stacking slots and service source codes
   // ***********************************************************
   localparam logic [3:0] SLOT_CCR = 4'h8;
   localparam logic [3:0] SRC_NONE = 4'h0;
   localparam logic [3:0] SRC_NONMASKABLE_REQUEST_PIN = 4'h1;
   localparam logic [3:0] SRC_IRQ = 4'h2;
   localparam logic [3:0] SRC_SWI = 4'h3;
   localparam logic [3:0] SRC_ILL = 4'h4;
   localparam logic [3:0] SRC_PER0 = 4'h8;
   localparam logic [15:0] RESTART_CYC = 16'h1000;
   // Implemented opcode maps, one bit per opcode, per page
   localparam logic [255:0] IMPL_P0 = {{254{1'b1}}, 2'h2};
   localparam logic [255:0] IMPL_P1 = {{128{1'b0}}, {128{1'b1}}};
   localparam logic [255:0] IMPL_P2 = {{192{1'b0}}, {64{1'b1}}};
   localparam logic [255:0] IMPL_P3 = {{224{1'b0}}, {32{1'b1}}};
   typedef enum logic [2:0] {
      ST_BOOT, ST_RUN, ST_STACK, ST_VECT, ST_WAIT, ST_STOP, ST_DELAY
   } ilc_state_t;
endpackage

// ==== ilc_top.sv ====
// Interrupt control, register stacking and wait/stop low-power control
module ilc_top #(
   parameter logic [15:0] RESTART_CYCLES = ilc_pkg::RESTART_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irq_n,
   input wire logic nonmaskable_request_pin_n,
   input wire logic [7:0] periph_event,
   input wire logic por_flag,
   input wire logic core_boundary,
   input wire logic core_op_valid,
   input wire logic [1:0] core_op_page,
   input wire logic [7:0] core_opcode,
   input wire logic [15:0] core_sp,
   input wire logic core_tap,
   input wire logic [7:0] core_tap_data,
   input wire logic core_rti,
   input wire logic [7:0] core_rti_ccr,
   input wire logic core_software_trap_instruction,
   input wire logic core_wait_instruction,
   input wire logic core_stop,
   output logic [7:0] condition_code_register,
   output logic core_halt,
   output logic svc_valid,
   output logic [3:0] svc_src,
   output logic svc_ret_first_byte,
   output logic stk_valid,
   output logic [3:0] stk_slot,
   output logic [15:0] stk_addr,
   output logic wait_rd_valid,
   output logic [15:0] wait_rd_addr,
   output logic osc_run,
   output logic clk_run,
   output logic timer_halt
);
   // ***********************************************************
   // Helpers
   // ***********************************************************
   function automatic logic is_illegal(input logic [1:0] pg, input logic [7:0] op);
      logic [255:0] m;
      m = ilc_pkg::IMPL_P0;
      case (pg)
         2'h1: m = ilc_pkg::IMPL_P1;
         2'h2: m = ilc_pkg::IMPL_P2;
         2'h3: m = ilc_pkg::IMPL_P3;
         default: m = ilc_pkg::IMPL_P0;
      endcase
      return ~m[op];
   endfunction

   function automatic logic [15:0] sp_minus(input logic [15:0] sp, input logic [3:0] n);
      return sp - {12'h000, n};
   endfunction

   // ***********************************************************
   // Pin synchronisers
   // ***********************************************************
   logic irq_s1_q, irq_s2_q, irq_s3_q, nonmaskable_request_pin_s1_q, nonmaskable_request_pin_s2_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_s1_q <= 1'b1;
         irq_s2_q <= 1'b1;
         irq_s3_q <= 1'b1;
         nonmaskable_request_pin_s1_q <= 1'b1;
         nonmaskable_request_pin_s2_q <= 1'b1;
      end else begin
         irq_s1_q <= irq_n;
         irq_s2_q <= irq_s1_q;
         irq_s3_q <= irq_s2_q;
         nonmaskable_request_pin_s1_q <= nonmaskable_request_pin_n;
         nonmaskable_request_pin_s2_q <= nonmaskable_request_pin_s1_q;
      end
   end

   // ***********************************************************
   // State and registers
   // ***********************************************************
   ilc_pkg::ilc_state_t st_q, st_d;
   logic x_q, x_d, i_q, i_d, s_q, s_d;
   logic [2:0] ctrl_q;
   logic [7:0] flag_q, flag_d, en_q;
   logic edge_q, edge_d;
   logic [3:0] cnt_q, cnt_d, src_q, src_d;
   logic [15:0] sp_q, sp_d, dly_q, dly_d;
   logic wflag_q, wflag_d, first_q, first_d;
   logic svc_q, svc_d;

   // ***********************************************************
   // Pending and priority
   // ***********************************************************
   wire irq_low = ~irq_s2_q;
   wire nonmaskable_request_pin_low = ~nonmaskable_request_pin_s2_q;
   wire irq_fall = irq_s3_q & ~irq_s2_q;
   wire edge_mode = ctrl_q[ilc_pkg::C_EDGE];
   wire irq_raw = edge_mode ? edge_q : irq_low;
   wire [7:0] per_req = flag_q & en_q;
   wire nonmaskable_request_pin_pend = nonmaskable_request_pin_low & ~x_q;
   wire irq_pend = irq_raw & ~i_q;
   wire per_pend = (|per_req) & ~i_q;
   wire pend_any = nonmaskable_request_pin_pend | irq_pend | per_pend;
   logic [3:0] per_src;
   always_comb begin
      per_src = ilc_pkg::SRC_PER0;
      for (int k = 7; k >= 0; k--) begin
         if (per_req[k]) begin
            per_src = ilc_pkg::SRC_PER0 + 4'(k);
         end
      end
   end
   // Nonmaskable pin first, then external pin, then peripherals
   wire [3:0] win_src = nonmaskable_request_pin_pend ? ilc_pkg::SRC_NONMASKABLE_REQUEST_PIN :
                        irq_pend ? ilc_pkg::SRC_IRQ : per_src;
   wire stop_wake = nonmaskable_request_pin_low | (irq_raw & ~i_q);
   wire illegal = core_op_valid & is_illegal(core_op_page, core_opcode);
   wire dly_on = ctrl_q[ilc_pkg::C_DLY];

   // ***********************************************************
   // Sequencer
   // ***********************************************************
   always_comb begin
      st_d = st_q;
      x_d = x_q;
      i_d = i_q;
      s_d = s_q;
      cnt_d = cnt_q;
      src_d = src_q;
      sp_d = sp_q;
      dly_d = dly_q;
      wflag_d = wflag_q;
      first_d = first_q;
      svc_d = 1'b0;
      case (st_q)
         ilc_pkg::ST_BOOT: begin
            dly_d = RESTART_CYCLES;
            st_d = por_flag ? ilc_pkg::ST_DELAY : ilc_pkg::ST_RUN;
         end
         ilc_pkg::ST_RUN: begin
            cnt_d = 4'h0;
            sp_d = core_sp;
            first_d = 1'b0;
            wflag_d = 1'b0;
            if (core_software_trap_instruction) begin
               src_d = ilc_pkg::SRC_SWI;
               st_d = ilc_pkg::ST_STACK;
            end else if (illegal) begin
               src_d = ilc_pkg::SRC_ILL;
               first_d = 1'b1;
               st_d = ilc_pkg::ST_STACK;
            end else if (core_wait_instruction) begin
               wflag_d = 1'b1;
               st_d = ilc_pkg::ST_STACK;
            end else if (core_stop) begin
               if (!s_q) begin
                  st_d = ilc_pkg::ST_STOP;
               end
            end else if (core_boundary && pend_any) begin
               src_d = win_src;
               st_d = ilc_pkg::ST_STACK;
            end else if (core_rti) begin
               x_d = core_rti_ccr[ilc_pkg::CCR_X];
               i_d = core_rti_ccr[ilc_pkg::CCR_I];
               s_d = core_rti_ccr[ilc_pkg::CCR_S];
            end else if (core_tap) begin
               x_d = x_q & core_tap_data[ilc_pkg::CCR_X];
               i_d = core_tap_data[ilc_pkg::CCR_I];
               s_d = core_tap_data[ilc_pkg::CCR_S];
            end
         end
         ilc_pkg::ST_STACK: begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == ilc_pkg::SLOT_CCR) begin
               st_d = wflag_q ? ilc_pkg::ST_WAIT : ilc_pkg::ST_VECT;
            end
         end
         ilc_pkg::ST_VECT: begin
            svc_d = 1'b1;
            i_d = 1'b1;
            if (src_q == ilc_pkg::SRC_NONMASKABLE_REQUEST_PIN) begin
               x_d = 1'b1;
            end
            st_d = ilc_pkg::ST_RUN;
         end
         ilc_pkg::ST_WAIT: begin
            if (pend_any) begin
               src_d = win_src;
               st_d = ilc_pkg::ST_VECT;
            end
         end
         ilc_pkg::ST_STOP: begin
            dly_d = RESTART_CYCLES;
            if (stop_wake) begin
               st_d = dly_on ? ilc_pkg::ST_DELAY : ilc_pkg::ST_RUN;
            end
         end
         ilc_pkg::ST_DELAY: begin
            dly_d = dly_q - 16'h0001;
            if (dly_q <= 16'h0001) begin
               st_d = ilc_pkg::ST_RUN;
            end
         end
         default: st_d = ilc_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= ilc_pkg::ST_BOOT;
         x_q <= 1'b1;
         i_q <= 1'b1;
         s_q <= 1'b1;
         cnt_q <= 4'h0;
         src_q <= ilc_pkg::SRC_NONE;
         sp_q <= 16'h0000;
         dly_q <= 16'h0000;
         wflag_q <= 1'b0;
         first_q <= 1'b0;
         svc_q <= 1'b0;
      end else begin
         st_q <= st_d;
         x_q <= x_d;
         i_q <= i_d;
         s_q <= s_d;
         cnt_q <= cnt_d;
         src_q <= src_d;
         sp_q <= sp_d;
         dly_q <= dly_d;
         wflag_q <= wflag_d;
         first_q <= first_d;
         svc_q <= svc_d;
      end
   end

   // ***********************************************************
   // Source flags and external edge latch
   // ***********************************************************
   logic wr_go;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   wire wr_lane0 = wr_go & wr_strb[0];
   wire flag_clr = wr_lane0 & (wr_addr == ilc_pkg::A_FLAG);
   wire irq_taken = svc_q & (src_q == ilc_pkg::SRC_IRQ);
   // Set wins over a simultaneous clear
   assign flag_d = (flag_q & ~(flag_clr ? wr_data[7:0] : 8'h00)) | periph_event;
   assign edge_d = irq_fall | (edge_q & ~irq_taken);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= ilc_pkg::FLAG_RST;
         edge_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         edge_q <= edge_d;
      end
   end

   // ***********************************************************
   // Outputs to core, bus and clock control
   // ***********************************************************
   wire in_stop = (st_d == ilc_pkg::ST_STOP);
   wire in_wait = (st_d == ilc_pkg::ST_WAIT);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         condition_code_register <= 8'h00;
         core_halt <= 1'b1;
         svc_valid <= 1'b0;
         svc_src <= ilc_pkg::SRC_NONE;
         svc_ret_first_byte <= 1'b0;
         stk_valid <= 1'b0;
         stk_slot <= 4'h0;
         stk_addr <= 16'h0000;
         wait_rd_valid <= 1'b0;
         wait_rd_addr <= 16'h0000;
         osc_run <= 1'b1;
         clk_run <= 1'b1;
         timer_halt <= 1'b0;
      end else begin
         condition_code_register <= {s_d, x_d, 1'b0, i_d, 4'h0};
         core_halt <= (st_d != ilc_pkg::ST_RUN);
         svc_valid <= svc_d;
         svc_src <= src_d;
         svc_ret_first_byte <= first_d;
         stk_valid <= (st_d == ilc_pkg::ST_STACK);
         stk_slot <= cnt_d;
         stk_addr <= sp_minus(sp_d, cnt_d);
         wait_rd_valid <= in_wait;
         wait_rd_addr <= sp_minus(sp_d, ilc_pkg::SLOT_CCR);
         osc_run <= ~in_stop;
         clk_run <= ~in_stop;
         timer_halt <= in_wait & i_d & ctrl_q[ilc_pkg::C_WATCHDOG_DISABLE_BIT];
      end
   end

   // ***********************************************************
   // AXI4-Lite slave
   // ***********************************************************
   logic aw_ok_q, w_ok_q;
   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs = s_axi_wvalid & s_axi_wready;
   wire aw_have = aw_ok_q | aw_hs;
   wire w_have = w_ok_q | w_hs;
   assign wr_go = aw_have & w_have & ~s_axi_bvalid;
   logic [7:0] awa_q;
   logic [31:0] wd_q;
   logic [3:0] ws_q;
   assign wr_addr = aw_hs ? s_axi_awaddr : awa_q;
   assign wr_data = w_hs ? s_axi_wdata : wd_q;
   assign wr_strb = w_hs ? s_axi_wstrb : ws_q;
   wire wr_map = (wr_addr == ilc_pkg::A_CTRL) | (wr_addr == ilc_pkg::A_FLAG) |
                 (wr_addr == ilc_pkg::A_EN) | (wr_addr == ilc_pkg::A_STAT);
   wire ar_hs = s_axi_arvalid & s_axi_arready;
   logic [31:0] rd_mux;
   logic rd_map;
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_map = 1'b1;
      case (s_axi_araddr)
         ilc_pkg::A_CTRL: rd_mux[2:0] = ctrl_q;
         ilc_pkg::A_FLAG: rd_mux[7:0] = flag_q;
         ilc_pkg::A_EN: rd_mux[7:0] = en_q;
         ilc_pkg::A_STAT: rd_mux[15:0] = {5'h00, st_q, condition_code_register};
         default: rd_map = 1'b0;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_q <= 1'b0;
         w_ok_q <= 1'b0;
         awa_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ilc_pkg::RESP_OK;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= ilc_pkg::RESP_OK;
         ctrl_q <= ilc_pkg::CTRL_RST;
         en_q <= ilc_pkg::EN_RST;
      end else begin
         if (aw_hs) begin
            awa_q <= s_axi_awaddr;
         end
         if (w_hs) begin
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         aw_ok_q <= aw_have & ~wr_go;
         w_ok_q <= w_have & ~wr_go;
         s_axi_awready <= ~aw_have & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready <= ~w_have & ~s_axi_wready & ~s_axi_bvalid;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? ilc_pkg::RESP_OK : ilc_pkg::RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_lane0 && wr_addr == ilc_pkg::A_CTRL) begin
            ctrl_q <= wr_data[2:0];
         end
         if (wr_lane0 && wr_addr == ilc_pkg::A_EN) begin
            en_q <= wr_data[7:0];
         end
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_map ? ilc_pkg::RESP_OK : ilc_pkg::RESP_ERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ***********************************************************
   // Checks
   // ***********************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence nonmaskable_request_pin_entry_s;
      st_q == ilc_pkg::ST_VECT && src_q == ilc_pkg::SRC_NONMASKABLE_REQUEST_PIN;
   endsequence
   sequence stack_done_s;
      st_q == ilc_pkg::ST_STACK && cnt_q == ilc_pkg::SLOT_CCR;
   endsequence

   reset_masks_a: assert property ($rose(aresetn) |-> x_q && i_q)
      else $error("masks not set after reset");
   x_no_set_a: assert property (x_q && !$past(st_q == ilc_pkg::ST_VECT) && !$past(core_rti)
      |-> $past(x_q) || !$past(aresetn))
      else $error("nonmaskable mask set by software");
   nonmaskable_request_pin_both_a: assert property (nonmaskable_request_pin_entry_s |=> x_q && i_q && svc_valid)
      else $error("nonmaskable entry left a mask clear");
   imask_keep_x_a: assert property (st_q == ilc_pkg::ST_VECT && src_q != ilc_pkg::SRC_NONMASKABLE_REQUEST_PIN
      |=> i_q && (x_q == $past(x_q)))
      else $error("maskable entry mask handling wrong");
   ccr_after_stack_a: assert property (stack_done_s
      |-> stk_valid && stk_slot == ilc_pkg::SLOT_CCR && i_d == i_q)
      else $error("mask set before flags stacked");
   stop_gate_a: assert property (st_q == ilc_pkg::ST_RUN && core_stop && s_q
      && !core_software_trap_instruction && !illegal && !core_wait_instruction
      |=> st_q == ilc_pkg::ST_RUN)
      else $error("stop entered while disabled");
   stop_clocks_a: assert property (st_q == ilc_pkg::ST_STOP |-> !osc_run && !clk_run)
      else $error("clocks running in stop");
   wait_osc_a: assert property (st_q == ilc_pkg::ST_WAIT |-> osc_run && wait_rd_valid
      && wait_rd_addr == sp_q - 16'h0008)
      else $error("wait outputs wrong");
   wait_exit_a: assert property (st_q == ilc_pkg::ST_WAIT && pend_any
      |=> st_q == ilc_pkg::ST_VECT ##1 svc_valid)
      else $error("wait not left on pending source");
   flag_set_a: assert property (periph_event[0] |=> flag_q[0])
      else $error("flag event lost");
   swi_mask_a: assert property (st_q == ilc_pkg::ST_RUN && core_software_trap_instruction
      |-> ##11 i_q && svc_src == ilc_pkg::SRC_SWI)
      else $error("software trap did not set mask");
endmodule

// ==== ilc_core_model.sv ====
// Behavioural execution core that issues one request pulse per command
module ilc_core_model (
   input wire logic aclk,
   input wire logic core_halt,
   input wire logic go,
   input wire logic [2:0] kind,
   input wire logic [7:0] dat,
   output logic core_boundary,
   output logic core_op_valid,
   output logic core_tap,
   output logic [7:0] core_tap_data,
   output logic core_rti,
   output logic [7:0] core_rti_ccr,
   output logic core_software_trap_instruction,
   output logic core_wait_instruction,
   output logic core_stop
);
   timeunit 1ns;
   timeprecision 1ps;
   logic run;
   assign run = go && !core_halt;
   initial begin
      {core_boundary, core_op_valid, core_tap, core_rti} = 4'h0;
      {core_software_trap_instruction, core_wait_instruction, core_stop} = 3'h0;
      {core_tap_data, core_rti_ccr} = 16'h0000;
   end
   // ***********************************************************
   // One pulse per command, withheld while halted
   // ***********************************************************
   always @(posedge aclk) begin
      core_boundary <= run && kind == 3'h0;
      core_op_valid <= run && kind == 3'h1;
      core_tap <= run && kind == 3'h2;
      core_rti <= run && kind == 3'h3;
      core_software_trap_instruction <= run && kind == 3'h4;
      core_wait_instruction <= run && kind == 3'h5;
      core_stop <= run && kind == 3'h6;
      // Data invalid outside its pulse
      core_tap_data <= (run && kind == 3'h2) ? dat : ~core_tap_data;
      core_rti_ccr <= (run && kind == 3'h3) ? dat : ~core_rti_ccr;
   end
endmodule

// ==== tb_top.sv ====
// Self-checking bench of the interrupt and low-power controller
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, go;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic irq_n, nonmaskable_request_pin_n, por_flag, core_boundary, core_op_valid, core_tap;
   logic core_rti, core_software_trap_instruction, core_wait_instruction, core_stop, core_halt;
   logic svc_valid, svc_ret_first_byte, stk_valid, wait_rd_valid, osc_run, clk_run, timer_halt;
   logic [1:0] s_axi_bresp, s_axi_rresp, core_op_page, rr;
   logic [2:0] kind;
   logic [3:0] s_axi_wstrb, svc_src, stk_slot;
   logic [7:0] s_axi_awaddr, s_axi_araddr, periph_event, core_opcode, core_tap_data, dat, cm;
   logic [7:0] core_rti_ccr, condition_code_register;
   logic [15:0] core_sp, stk_addr, wait_rd_addr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   int err_total = 0, tests_run = 0, cyc = 0, k, n;
   ilc_top #(.RESTART_CYCLES(16'h0008)) dut_u (.*);
   ilc_core_model core_u (.*);
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         complete_run;
      end
   end
   task automatic complete_run;
      if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
         err_total++;
      end
   endtask
   task automatic aw(input logic [7:0] a, input logic [31:0] d);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic ar(input logic [7:0] a);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      {rd, rr} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask
   task automatic op(input logic [2:0] c, input logic [7:0] d);
      {kind, dat, go} <= {c, d, 1'b1};
      @(posedge aclk);
      go <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic cc;
      repeat (2) @(posedge aclk);
      chk("ccr", cm, condition_code_register);
   endtask
   // Flag transfer or return: mask bit X may only be set by a return
   task automatic fl(input logic [2:0] c, input logic [7:0] d);
      op(c, d);
      cm = {d[7], d[6] & (c == 3'h3 || cm[6]), 1'b0, d[4], 4'h0};
      cc;
   endtask
   task automatic svc(input logic [3:0] s, input int p, input logic [7:0] m);
      n = 0;
      do begin
         @(posedge aclk);
         if (stk_valid === 1'b1) begin
            chk("slot", n, stk_slot);
            chk("addr", core_sp - n, stk_addr);
            n++;
         end
      end while (svc_valid !== 1'b1);
      chk("src", s, svc_src);
      chk("ret", s == ilc_pkg::SRC_ILL, svc_ret_first_byte);
      chk("push", p, n);
      cm = cm | m;
      cc;
   endtask
   // ***********************************************************
   // Stimulus and checks
   // ***********************************************************
   initial begin
      void'($urandom(46141));
      {aresetn, go, kind, dat, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} <= '0;
      {periph_event, core_op_page, core_opcode} <= '0;
      {s_axi_wstrb, irq_n, nonmaskable_request_pin_n, por_flag} <= 7'h7F;
      core_sp <= 16'h0200 + 16'($urandom % 512);
      cm = 8'hD0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (5) @(posedge aclk);
      chk("halt", 1, core_halt);
      while (core_halt !== 1'b0) @(posedge aclk);
      chk("ccr", 8'hD0, condition_code_register);
      ar(ilc_pkg::A_CTRL);
      chk("ctrl", 32'h1, rd);
      ar(8'h10);
      chk("resp", ilc_pkg::RESP_ERR, rr);
      fl(3'h2, 8'h00);
      fl(3'h2, 8'hFF);
      fl(3'h2, 8'h00);
      k = $urandom % 8;
      aw(ilc_pkg::A_EN, 32'h1 << k);
      periph_event <= 8'h1 << k;
      @(posedge aclk);
      periph_event <= 8'h00;
      ar(ilc_pkg::A_FLAG);
      chk("flag", 32'h1 << k, rd);
      op(3'h0, 8'h00);
      svc(ilc_pkg::SRC_PER0 + k, 9, 8'h10);
      fl(3'h3, 8'h00);
      op(3'h0, 8'h00);
      svc(ilc_pkg::SRC_PER0 + k, 9, 8'h10);
      aw(ilc_pkg::A_FLAG, 32'h1 << k);
      ar(ilc_pkg::A_FLAG);
      chk("flag", 32'h0, rd);
      fl(3'h3, 8'h00);
      {irq_n, nonmaskable_request_pin_n} <= 2'h0;
      repeat (3) @(posedge aclk);
      op(3'h0, 8'h00);
      svc(4'h1, 9, 8'h50);
      nonmaskable_request_pin_n <= 1'b1;
      fl(3'h3, 8'h00);
      op(3'h0, 8'h00);
      svc(ilc_pkg::SRC_IRQ, 9, 8'h10);
      irq_n <= 1'b1;
      fl(3'h3, 8'h00);
      for (k = 0; k < 4; k++) begin
         {core_op_page, core_opcode} <= {k[1:0], (k == 0) ? 8'h00 : 8'hFF};
         op(3'h1, 8'h00);
         svc(ilc_pkg::SRC_ILL, 9, 8'h10);
         fl(3'h3, 8'h00);
      end
      fl(3'h2, 8'h10);
      op(3'h4, 8'h00);
      svc(4'h3, 9, 8'h10);
      aw(ilc_pkg::A_CTRL, 32'h3);
      op(3'h5, 8'h00);
      while (wait_rd_valid !== 1'b1) @(posedge aclk);
      @(posedge aclk);
      chk("rdaddr", core_sp - 16'h0008, wait_rd_addr);
      chk("timer", 1, timer_halt);
      chk("osc", 1, osc_run);
      nonmaskable_request_pin_n <= 1'b0;
      svc(4'h1, 0, 8'h50);
      nonmaskable_request_pin_n <= 1'b1;
      fl(3'h3, 8'h00);
      fl(3'h2, 8'h80);
      op(3'h6, 8'h00);
      repeat (3) @(posedge aclk);
      chk("halt", 0, core_halt);
      fl(3'h2, 8'h00);
      op(3'h6, 8'h00);
      repeat (3) @(posedge aclk);
      chk("osc", 0, osc_run);
      chk("clk", 0, clk_run);
      irq_n <= 1'b0;
      n = 0;
      while (core_halt !== 1'b0) begin
         @(posedge aclk);
         n++;
      end
      chk("delay", 1, n >= 8);
      op(3'h0, 8'h00);
      svc(ilc_pkg::SRC_IRQ, 9, 8'h10);
      irq_n <= 1'b1;
      fl(3'h3, 8'h00);
      aw(ilc_pkg::A_CTRL, 32'h4);
      irq_n <= 1'b0;
      repeat (4) @(posedge aclk);
      irq_n <= 1'b1;
      repeat (4) @(posedge aclk);
      op(3'h0, 8'h00);
      svc(ilc_pkg::SRC_IRQ, 9, 8'h10);
      complete_run;
   end
endmodule
